// ### adr_params.svh
// register offsets, field positions and reset values of the aux converter and interrupt bank
`ifndef ADR_PARAMS_SVH
`define ADR_PARAMS_SVH

`define ADR_OFS_LEVEL_LO   5'h11
`define ADR_OFS_LEVEL_HI   5'h12
`define ADR_OFS_IRQ        5'h19
`define ADR_OFS_REV        5'h1F

`define ADR_FLD_LVL_HI     1:0
`define ADR_BIT_SIGN       7
`define ADR_BIT_DIR        6
`define ADR_BIT_PD         5
`define ADR_BIT_DATA_ERR   7
`define ADR_BIT_SYNC_ERR   6
`define ADR_BIT_ERR_TYPE   4
`define ADR_BIT_DATA_EN    3
`define ADR_BIT_SYNC_EN    2
`define ADR_BIT_LOOPBACK   0

`define ADR_RST_BYTE       8'h00
`define ADR_RST_HI2        2'h0
`define ADR_ZERO_BYTE      8'h00
// arbitrary neutral revision value
`define ADR_REV_DEFAULT    8'h5A

`endif

// ### adr_pkg.sv
// types shared by the aux converter and interrupt bank
package adr_pkg;
   typedef logic [7:0] adr_byte_t;
   typedef logic [4:0] adr_addr_t;
endpackage

// ### adr_sticky_flag.sv
// one latched event flag whose set wins over a clear
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_sticky_flag
   import adr_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // control
   input  wire logic set,
   input  wire logic clr,
   // state
   output logic      flag
);
   typedef struct packed {
      logic flag_q;
   } adr_flag_st_t;

   adr_flag_st_t st_q;
   adr_flag_st_t st_d;

   // set beats clear so an event in the read cycle survives for the next read
   always_comb begin
      st_d = st_q;
      if (clr) begin
         st_d.flag_q = 1'b0;
      end
      if (set) begin
         st_d.flag_q = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign flag = st_q.flag_q;
endmodule // adr_sticky_flag

// ### adr_bank.sv
// aux converter 2 control, timing interrupt and revision register bank
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_bank
   import adr_pkg::*;
#(
   parameter adr_byte_t HW_REV = `ADR_REV_DEFAULT
)
(
   // clock and reset
   input  wire logic      sys_clk,
   input  wire logic      rst,
   // register access from the serial port
   input  wire adr_addr_t reg_addr,
   input  wire logic      reg_wr,
   input  wire adr_byte_t reg_wdata,
   input  wire logic      reg_rd,
   output adr_byte_t      reg_rdata,
   output logic           reg_rvalid,
   // timing checkers
   input  wire logic      data_timing_err,
   input  wire logic      data_err_setup,
   input  wire logic      sync_timing_err,
   // sync path
   input  wire logic      sync_in_pin,
   input  wire logic      sync_out_recv,
   output logic           sync_in_path,
   // aux converter 2
   output logic [9:0]     aux2_level,
   output logic           aux2_out_pos,
   output logic           aux2_out_neg,
   output logic           aux2_sink,
   output logic           aux2_power_down,
   // interrupt
   output logic           irq
);
   //////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      adr_byte_t  lvl_lo_q;
      logic [1:0] lvl_hi_q;
      logic       sign_q;
      logic       dir_q;
      logic       pd_q;
      logic       err_type_q;
      logic       data_en_q;
      logic       sync_en_q;
      logic       loop_q;
      adr_byte_t  rdata_q;
      logic       rvalid_q;
   } adr_bank_st_t;

   adr_bank_st_t st_q;
   adr_bank_st_t st_d;
   logic         data_flag;
   logic         sync_flag;
   logic         irq_rd;
   adr_byte_t    irq_byte;
   adr_byte_t    hi_byte;

   assign irq_rd = reg_rd && (reg_addr == `ADR_OFS_IRQ);

   //////////////////////////////////////////////////////////////////////////
   // latched timing flags, cleared by reading the interrupt byte
   adr_sticky_flag u_data_flag (
      .sys_clk (sys_clk),
      .rst     (rst),
      .set     (data_timing_err),
      .clr     (irq_rd),
      .flag    (data_flag)
   );

   adr_sticky_flag u_sync_flag (
      .sys_clk (sys_clk),
      .rst     (rst),
      .set     (sync_timing_err),
      .clr     (irq_rd),
      .flag    (sync_flag)
   );

   //////////////////////////////////////////////////////////////////////////
   // read images of the mixed bytes
   always_comb begin
      irq_byte = `ADR_ZERO_BYTE;
      irq_byte[`ADR_BIT_DATA_ERR] = data_flag;
      irq_byte[`ADR_BIT_SYNC_ERR] = sync_flag;
      irq_byte[`ADR_BIT_ERR_TYPE] = st_q.err_type_q;
      irq_byte[`ADR_BIT_DATA_EN]  = st_q.data_en_q;
      irq_byte[`ADR_BIT_SYNC_EN]  = st_q.sync_en_q;
      irq_byte[`ADR_BIT_LOOPBACK] = st_q.loop_q;
      hi_byte = `ADR_ZERO_BYTE;
      hi_byte[`ADR_BIT_SIGN] = st_q.sign_q;
      hi_byte[`ADR_BIT_DIR]  = st_q.dir_q;
      hi_byte[`ADR_BIT_PD]   = st_q.pd_q;
      hi_byte[`ADR_FLD_LVL_HI] = st_q.lvl_hi_q;
   end

   //////////////////////////////////////////////////////////////////////////
   // writes, error type capture and registered read data
   always_comb begin
      st_d = st_q;
      st_d.rvalid_q = reg_rd;
      // type follows the latest data error so it matches the flag it explains
      if (data_timing_err) begin
         st_d.err_type_q = data_err_setup;
      end
      if (reg_wr) begin
         case (reg_addr)
            `ADR_OFS_LEVEL_LO: begin
               st_d.lvl_lo_q = reg_wdata;
            end
            `ADR_OFS_LEVEL_HI: begin
               st_d.lvl_hi_q = reg_wdata[`ADR_FLD_LVL_HI];
               st_d.sign_q   = reg_wdata[`ADR_BIT_SIGN];
               st_d.dir_q    = reg_wdata[`ADR_BIT_DIR];
               st_d.pd_q     = reg_wdata[`ADR_BIT_PD];
            end
            `ADR_OFS_IRQ: begin
               // flags and type are read only, writes to them are dropped
               st_d.data_en_q = reg_wdata[`ADR_BIT_DATA_EN];
               st_d.sync_en_q = reg_wdata[`ADR_BIT_SYNC_EN];
               st_d.loop_q    = reg_wdata[`ADR_BIT_LOOPBACK];
            end
            default: begin
               // reserved and read-only addresses ignore writes
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `ADR_OFS_LEVEL_LO: st_d.rdata_q = st_q.lvl_lo_q;
            `ADR_OFS_LEVEL_HI: st_d.rdata_q = hi_byte;
            // sampled before the clear lands, so the read sees the events
            `ADR_OFS_IRQ:      st_d.rdata_q = irq_byte;
            `ADR_OFS_REV:      st_d.rdata_q = HW_REV;
            default:           st_d.rdata_q = `ADR_ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;  // all defaults are zero, power-down clear
      end else begin
         st_q <= st_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs
   // plain binary word, so current rises monotonically with the code
   assign aux2_level      = {st_q.lvl_hi_q, st_q.lvl_lo_q};
   assign aux2_out_pos    = !st_q.pd_q && !st_q.sign_q;
   assign aux2_out_neg    = !st_q.pd_q && st_q.sign_q;
   assign aux2_sink       = st_q.dir_q;
   assign aux2_power_down = st_q.pd_q;
   assign sync_in_path    = st_q.loop_q ? sync_out_recv : sync_in_pin;
   assign irq = (data_flag && st_q.data_en_q) || (sync_flag && st_q.sync_en_q);
   assign reg_rdata  = st_q.rdata_q;
   assign reg_rvalid = st_q.rvalid_q;
endmodule // adr_bank

// ### adr_bank_monitor.sv
// assertion checker for the aux converter and timing interrupt bank
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_bank_monitor
   import adr_pkg::*;
#(
   parameter adr_byte_t HW_REV = `ADR_REV_DEFAULT
)
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // register port
   input wire adr_addr_t  reg_addr,
   input wire logic       reg_wr,
   input wire adr_byte_t  reg_wdata,
   input wire logic       reg_rd,
   input wire adr_byte_t  reg_rdata,
   // events and outputs
   input wire logic       data_timing_err,
   input wire logic       data_err_setup,
   input wire logic       sync_timing_err,
   input wire logic [9:0] aux2_level,
   input wire logic       aux2_out_neg,
   input wire logic       aux2_power_down,
   input wire logic       irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // decoded strobes; mid keeps a flag from being cleared or retyped between event and read
   wire w_hi  = reg_wr && reg_addr == 5'h12;
   wire r_irq = reg_rd && reg_addr == 5'h19;
   wire quiet = !data_timing_err && !sync_timing_err;
   wire mid   = quiet && !r_irq;
   sequence s_data_rd; data_timing_err ##1 mid ##1 r_irq; endsequence
   sequence s_twice_rd; (r_irq && quiet) ##1 quiet ##1 r_irq; endsequence
   sequence s_sync_rd; sync_timing_err ##1 mid ##1 r_irq; endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_level_hi: assert property (w_hi |=> aux2_level[9:8] == $past(reg_wdata[1:0]))
      else $error("level high bits not applied");
   a_pin_select: assert property (w_hi |=> aux2_out_neg == $past(reg_wdata[7] & ~reg_wdata[5]))
      else $error("negative pin select wrong");
   a_power_off: assert property (w_hi |=> aux2_power_down == $past(reg_wdata[5]))
      else $error("power down not applied");
   a_data_flag: assert property (s_data_rd |=> reg_rdata[7] && reg_rdata[4] == $past(data_err_setup, 3))
      else $error("data flag or type lost");
   a_sync_flag: assert property (s_sync_rd |=> reg_rdata[6])
      else $error("sync flag lost");
   a_read_clear: assert property (s_twice_rd |=> reg_rdata[7:6] == 2'h0)
      else $error("flags survived a read");
   a_irq_drop: assert property (r_irq && quiet |=> !irq)
      else $error("interrupt held after clearing read");
   a_rev_fixed: assert property (reg_rd && reg_addr == 5'h1F |=> reg_rdata == HW_REV)
      else $error("revision byte wrong");
endmodule // adr_bank_monitor

// ### tb_adr_bank.sv
// self-checking bench for the aux converter and timing interrupt bank
`timescale 1ns/1ps
`include "adr_params.svh"
module tb_adr_bank;
   logic       sys_clk = 1'h0, rst = 1'h1, wr = 1'h0, rd_s = 1'h0, d_err = 1'h0;
   logic       d_set = 1'h0, s_err = 1'h0, s_pin = 1'h0, s_out = 1'h0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   wire  [7:0] rdata;
   wire  [9:0] lvl;
   wire        rv, s_path, a_pos, a_neg, a_snk, a_pd, irq;
   int         error_cnt = 0, n_tests = 0, cyc = 0;
   adr_bank adr_bank_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd_s), .reg_rdata(rdata), .reg_rvalid(rv),
      .data_timing_err(d_err), .data_err_setup(d_set), .sync_timing_err(s_err),
      .sync_in_pin(s_pin), .sync_out_recv(s_out), .sync_in_path(s_path), .aux2_level(lvl),
      .aux2_out_pos(a_pos), .aux2_out_neg(a_neg), .aux2_sink(a_snk),
      .aux2_power_down(a_pd), .irq(irq));
   // clock and a hang guard well above the fewer than fifty cycles the tests need
   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // compare, bus cycles and event pulses; inputs move on the falling edge only
   task automatic chk(logic [9:0] s, logic [9:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic wrt(logic [4:0] a, logic [7:0] d);
      @(negedge sys_clk) {wr, addr, wdata} = {1'h1, a, d};
      @(negedge sys_clk) wr = 1'h0;
   endtask
   task automatic rdc(logic [4:0] a, logic [7:0] e);
      @(negedge sys_clk) {rd_s, addr} = {1'h1, a};
      @(negedge sys_clk) rd_s = 1'h0;
      chk(10'({rv, rdata}), 10'({1'h1, e}));
   endtask
   task automatic ev(logic d, logic st, logic sy);
      @(negedge sys_clk) {d_err, d_set, s_err} = {d, st, sy};
      @(negedge sys_clk) {d_err, s_err} = 2'h0;
   endtask
   // scenarios
   task automatic t_reset;
      chk(10'({a_pos, a_neg, a_pd, irq}), 10'h008);
      rdc(5'h11, 8'h00);
      rdc(5'h19, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_aux;
      wrt(5'h11, 8'h5C);
      wrt(5'h12, 8'hA3);
      chk(lvl, 10'h35C);
      chk(10'({a_pos, a_neg, a_snk, a_pd}), 10'h001);
      rdc(5'h12, 8'hA3);
      wrt(5'h12, 8'hC2);
      chk(10'({lvl[9:8], a_pos, a_neg, a_snk, a_pd}), 10'h026);
      $display("aux test done");
   endtask
   task automatic t_irq;
      wrt(5'h19, 8'h0C);
      ev(1'h1, 1'h1, 1'h0);
      chk(10'(irq), 10'h001);
      rdc(5'h19, 8'h9C);
      chk(10'(irq), 10'h000);
      rdc(5'h19, 8'h1C);
      ev(1'h0, 1'h0, 1'h1);
      rdc(5'h19, 8'h5C);
      wrt(5'h19, 8'hC0);
      ev(1'h1, 1'h0, 1'h1);
      chk(10'(irq), 10'h000);
      rdc(5'h19, 8'hC0);
      $display("interrupt test done");
   endtask
   task automatic t_misc;
      {s_pin, s_out} = 2'h2;
      #1 chk(10'(s_path), 10'h001);
      wrt(5'h19, 8'h01);
      chk(10'(s_path), 10'h000);
      wrt(5'h15, 8'hFF);
      rdc(5'h15, 8'h00);
      wrt(5'h1F, 8'h00);
      rdc(5'h1F, `ADR_REV_DEFAULT);
      $display("loopback and reserved test done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(negedge sys_clk);
      rst = 1'h0;
      t_reset;
      t_aux;
      t_irq;
      t_misc;
      finish_test;
   end
endmodule // tb_adr_bank
bind adr_bank adr_bank_monitor #(.HW_REV(HW_REV)) adr_bank_monitor_i (.sys_clk(sys_clk),
   .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .data_timing_err(data_timing_err), .data_err_setup(data_err_setup),
   .sync_timing_err(sync_timing_err), .aux2_level(aux2_level), .aux2_out_neg(aux2_out_neg),
   .aux2_power_down(aux2_power_down), .irq(irq));
